// ===== bench/vectored_interrupt_trap_unit_bench.sv
// self-checking bench for the vectored interrupt and trap unit
`timescale 1ns/1ns
module vectored_interrupt_trap_unit_bench;
  import vitu_pkg::*;
  logic            clk = 1'h0, rst_n = 1'h0, wr = 1'h0, rd = 1'h0, rd_d = 1'h0;
  logic            swc = 1'h0, run = 1'h0, intr = 1'h0, two = 1'h0, iret = 1'h0;
  logic            xbusy = 1'h0, dbrk = 1'h0, ext_trap = 1'h0;
  logic [AW-1:0]   addr = 3'h0;
  logic [DW-1:0]   wdata = 16'h0000, pc = 16'h0000, seed = 16'hD640;
  logic [NSRC-1:0] ev = 10'h000, acc = 10'h000;
  logic [DW-1:0]   rdata, tvec, srp, npc;
  logic [3:0]      code;
  logic            tv, ack, trap_out, trap_oe, rom_low, ram_low, sleep_o;
  logic            done, done_i, done_t, trap_pin;
  logic [15:0]     rq[$], tq[$];
  logic [15:0]     svc_q[4] = '{16'h0015, 16'h001C, 16'h0012, 16'h0011};
  int              comparisons = 0, miscompares = 0;
  wire [15:0]      st = {7'h00, sleep_o, rom_low, ram_low, trap_oe, ack, code};

  always #5 clk = ~clk;

  vitu_core i_vitu_core (
    .REF_CLK(clk), .RST_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
    .REG_RD(rd), .REG_RDATA(rdata), .SRC_EVENT(ev), .SRC_DATA_ACCESS(acc), .SW_CALL(swc),
    .INSTR_DONE(done), .INSTR_INTERRUPTIBLE(done_i), .INSTR_TWO_CYCLE(done_t),
    .NEXT_PC(npc), .IRETURN(iret), .XFER_BUSY(xbusy), .DEBUG_BREAK(dbrk),
    .TRAP_IN(trap_pin), .TRAP_OUT(trap_out), .TRAP_OE(trap_oe), .TAKE_VALID(tv),
    .TAKE_VECTOR(tvec), .SAVED_RETURN_POINTER(srp), .SERVICE_ACK_OUT(ack),
    .SERVICE_CODE_OUT(code), .ROM_LOW_PROGRAM_MAP(rom_low), .PROGRAM_RAM_LOW(ram_low),
    .CORE_SLEEP(sleep_o));

  vitu_partner i_vitu_partner (
    .run(run), .intr(intr), .two(two), .pc(pc), .ext_trap(ext_trap), .sleep(sleep_o),
    .trap_out(trap_out), .trap_oe(trap_oe), .done(done), .done_intr(done_i),
    .done_two(done_t), .next_pc(npc), .trap_pin(trap_pin));

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    tick(1);
    wr <= 1'h0;
    tick(1);
  endtask

  // the note is queued first, the monitor pops it when the data stand
  task automatic rd_reg(input logic [2:0] a, input logic [15:0] exp);
    rq.push_back(exp);
    addr <= a;
    rd <= 1'h1;
    tick(1);
    rd <= 1'h0;
    tick(1);
  endtask

  task automatic ret();
    iret <= 1'h1;
    tick(1);
    iret <= 1'h0;
  endtask

  task automatic wait_take();
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (tv !== 1'h1 && n < 40);
    if (n >= 40) chk(16'h0000, 16'h0001);
  endtask

  task automatic end_sim();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // an unexpected redirect finds an empty queue and cannot match
  always @(posedge clk) begin
    rd_d <= rd;
    if (rd_d) chk(rdata, rq.size() ? rq.pop_front() : 16'hXXXX);
    if (tv === 1'h1) chk(tvec, tq.size() ? tq.pop_front() : 16'hXXXX);
  end

  initial begin
    tick(3000);
    miscompares++;
    end_sim();
  end

  initial begin
    tick(8);
    rst_n <= 1'h1;
    run <= 1'h1;
    intr <= 1'h1;
    @(negedge clk);
    chk(st, 16'h0000);
    @(posedge clk);
    seed = lfsr_next(seed);
    wr_reg(3'h7, seed);
    for (int i = 0; i < 8; i++) rd_reg(i[2:0], 16'h0000);
    ev <= 10'h00C;
    tick(1);
    ev <= 10'h000;
    rd_reg(3'h1, 16'h000C);
    tq.push_back(16'h0010);
    wr_reg(3'h0, 16'h0008);
    wait_take();
    @(negedge clk);
    chk(st, 16'h001C);
    @(posedge clk);
    ret();
    tick(1);
    @(negedge clk);
    chk(st, 16'h0000);
    @(posedge clk);
    rd_reg(3'h1, 16'h0004);
    wr_reg(3'h1, 16'h0004);
    wr_reg(3'h0, 16'h0000);
    for (int i = 0; i < NSRC; i++) begin
      ev <= 10'h001 << i;
      tick(1);
      ev <= 10'h000;
      rd_reg(3'h1, 16'h0001 << i);
      if (W1C_MASK[i]) wr_reg(3'h1, 16'h0001 << i);
      else begin
        acc <= 10'h001 << i;
        tick(1);
        acc <= 10'h000;
      end
      rd_reg(3'h1, 16'h0000);
    end
    wr_reg(3'h0, 16'h03FF);
    tq = {16'h0034, 16'h0010, 16'h0001, 16'h0002};
    ev <= 10'h109;
    swc <= 1'h1;
    tick(1);
    ev <= 10'h000;
    swc <= 1'h0;
    foreach (svc_q[k]) begin
      wait_take();
      @(negedge clk);
      chk(st, svc_q[k]);
      @(posedge clk);
      acc <= 10'h100;
      ret();
      acc <= 10'h000;
    end
    wr_reg(3'h0, 16'h0008);
    intr <= 1'h0;
    ev <= 10'h008;
    tick(1);
    ev <= 10'h000;
    repeat (6) begin
      seed = lfsr_next(seed);
      pc <= seed;
      two <= seed[0];
      tick(1);
      @(negedge clk);
      chk(srp, seed[0] ? seed : seed + 16'h0001);
      @(posedge clk);
    end
    tq.push_back(16'h0010);
    intr <= 1'h1;
    wait_take();
    @(posedge clk);
    wr_reg(3'h2, 16'h4000);
    wr_reg(3'h3, 16'h0001);
    @(negedge clk);
    chk(st, 16'h007C);
    @(posedge clk);
    dbrk <= 1'h1;
    run <= 1'h0;
    tick(1);
    dbrk <= 1'h0;
    @(negedge clk);
    chk({15'h0000, trap_out}, 16'h0001);
    tick(6);
    tq.push_back(16'h0003);
    run <= 1'h1;
    wait_take();
    @(negedge clk);
    chk(st, 16'h00BC);
    @(posedge clk);
    ret();
    @(negedge clk);
    chk(st, 16'h007C);
    @(posedge clk);
    ret();
    tick(1);
    @(negedge clk);
    chk(st, 16'h0060);
    @(posedge clk);
    wr_reg(3'h3, 16'h0000);
    wr_reg(3'h2, 16'h0000);
    wr_reg(3'h0, 16'h0000);
    tq.push_back(16'h0046);
    ext_trap <= 1'h1;
    tick(3);
    @(negedge clk);
    chk({15'h0000, tv}, 16'h0000);
    @(negedge clk);
    chk({15'h0000, tv}, 16'h0001);
    @(negedge clk);
    chk(st, 16'h0017);
    @(posedge clk);
    ext_trap <= 1'h0;
    tick(2);
    ext_trap <= 1'h1;
    tick(2);
    ext_trap <= 1'h0;
    tick(8);
    ret();
    tick(1);
    @(negedge clk);
    chk(st, 16'h0000);
    @(posedge clk);
    wr_reg(3'h3, 16'h0002);
    tq.push_back(16'h0003);
    ext_trap <= 1'h1;
    wait_take();
    @(negedge clk);
    chk(st, 16'h0080);
    @(posedge clk);
    ext_trap <= 1'h0;
    ret();
    @(negedge clk);
    chk(st, 16'h0000);
    @(posedge clk);
    wr_reg(3'h3, 16'h0000);
    xbusy <= 1'h1;
    wr_reg(3'h2, 16'h8000);
    tick(4);
    @(negedge clk);
    chk(st, 16'h0000);
    @(posedge clk);
    xbusy <= 1'h0;
    tick(2);
    @(negedge clk);
    chk(st, 16'h0100);
    @(posedge clk);
    ev <= 10'h002;
    tick(1);
    ev <= 10'h000;
    @(negedge clk);
    chk(st, 16'h0000);
    @(posedge clk);
    rd_reg(3'h2, 16'h0000);
    rd_reg(3'h1, 16'h0002);
    rst_n <= 1'h0;
    tick(2);
    rst_n <= 1'h1;
    rd_reg(3'h1, 16'h0000);
    tick(2);
    chk(16'(rq.size() + tq.size()), 16'h0000);
    end_sim();
  end
endmodule

// ===== bench/vitu_partner.sv
// core sequencer and trap pin stand-in facing the interrupt unit
`timescale 1ns/1ns
module vitu_partner (
  input  wire logic        run,
  input  wire logic        intr,
  input  wire logic        two,
  input  wire logic [15:0] pc,
  input  wire logic        ext_trap,
  input  wire logic        sleep,
  input  wire logic        trap_out,
  input  wire logic        trap_oe,
  output logic             done,
  output logic             done_intr,
  output logic             done_two,
  output logic [15:0]      next_pc,
  output logic             trap_pin
);
  // a sleeping core retires nothing
  assign done      = run & ~sleep;
  assign done_intr = intr;
  assign done_two  = two;
  // scrambled address off a retire, so a stale sample is caught
  assign next_pc   = done ? pc : ~pc;
  // wired pin: the unit drives it when enabled, else the outside party
  assign trap_pin  = trap_oe ? trap_out : ext_trap;
endmodule

// ===== design/vitu_core.sv
// vectored interrupt and trap unit: masking, priority, service status, traps, sleep
// Summary of operation
// - Enable bit one unmasks its interrupt; zero masks it.
// - Software interrupt and traps have no enable bit and cannot be masked.
// - Unmasked request vectors fetch to its address when no service is in progress.
// - Masked request still latches pending; unmasking it later starts normal entry.
// - Acknowledge high during interrupt or user trap service, low at return.
// - Service code: zero idle, seven for user trap, table code otherwise.
// - Debug traps leave acknowledge and service code untouched.
// - Each source has a fixed vector and priority; user trap highest.
// - Host input-full clears on data read; output-empty clears on data write.
// - Serial full/empty flags clear on matching data register read or write.
// - Scan port interrupt clears when its data register is read.
// - Writing one to ext a, ext b or timer pending bit clears it.
// - Return clears the serviced ext or timer bit, leaving others pending.
// - Trap pin is an input after reset; asserting it forces a user trap.
// - User trap vectors to 0x46, debug trap to 0x3.
// - Trap takes control four cycles after reaching the pin.
// - The instruction in flight, wait-states included, finishes before trap entry.
// - Return pointer holds next address, or one beyond for one-cycle instructions.
// - Debug trap forces the rom-low program map; return restores the prior map.
// - Trap pin as output asserts at breakpoint; as input with the control debug bit set it enters debug code.
// - Sleep bit enters sleep after one more instruction; detection stays active.
// - Transfers finish before sleep; first interrupt clears the bit and wakes.
// - Simultaneous requests serviced in priority order after interruptible instructions.
// - Non-interruptible instructions block vectored interrupts but not traps.
// - Trap requests are ignored while a trap routine runs.
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
module vitu_core
  import vitu_pkg::*;
(
  input  wire logic            REF_CLK,
  input  wire logic            RST_N,
  input  wire logic [AW-1:0]   REG_ADDR,
  input  wire logic [DW-1:0]   REG_WDATA,
  input  wire logic            REG_WR,
  input  wire logic            REG_RD,
  output logic      [DW-1:0]   REG_RDATA,
  input  wire logic [NSRC-1:0] SRC_EVENT,
  input  wire logic [NSRC-1:0] SRC_DATA_ACCESS,
  input  wire logic            SW_CALL,
  input  wire logic            INSTR_DONE,
  input  wire logic            INSTR_INTERRUPTIBLE,
  input  wire logic            INSTR_TWO_CYCLE,
  input  wire logic [DW-1:0]   NEXT_PC,
  input  wire logic            IRETURN,
  input  wire logic            XFER_BUSY,
  input  wire logic            DEBUG_BREAK,
  input  wire logic            TRAP_IN,
  output logic                 TRAP_OUT,
  output logic                 TRAP_OE,
  output logic                 TAKE_VALID,
  output logic      [DW-1:0]   TAKE_VECTOR,
  output logic      [DW-1:0]   SAVED_RETURN_POINTER,
  output logic                 SERVICE_ACK_OUT,
  output logic      [3:0]      SERVICE_CODE_OUT,
  output logic                 ROM_LOW_PROGRAM_MAP,
  output logic                 PROGRAM_RAM_LOW,
  output logic                 CORE_SLEEP
);

  function automatic vitu_pick_t pick_highest(input logic [NSRC-1:0] req);
    vitu_pick_t r;
    logic [4:0] best;
    r    = '0;
    best = '0;
    for (int i = 0; i < NSRC; i++) begin
      if (req[i] && SRC_PRIO[i] > best) begin
        best    = SRC_PRIO[i];
        r.found = 1'b1;
        r.idx   = 4'(i);
      end
    end
    return r;
  endfunction

  logic [NSRC-1:0] enable;
  logic [NSRC-1:0] pending;
  logic            sw_pending;
  logic            sleep_bit;
  logic            ram_low;
  logic            trap_dir_out;
  logic            trap_pin_debug;
  logic            isr_active;
  logic [3:0]      isr_src;
  logic            isr_is_sw;
  vitu_svc_t       isr_svc;
  vitu_trap_st_t   trap_st;
  logic [2:0]      trap_cnt;
  logic            trap_debug;
  logic            trap_in_q;
  logic            sleep_armed;

  logic            wr_enable;
  logic            wr_pending;
  logic            wr_flags;
  logic            wr_control;
  logic            trap_req;
  logic            trap_req_debug;
  logic            trap_take;
  logic            int_ok;
  logic            int_take;
  vitu_pick_t      pick;
  logic            wake;
  logic [NSRC-1:0] clr_access;
  logic [NSRC-1:0] clr_write;
  logic [NSRC-1:0] clr_return;

  assign wr_enable  = REG_WR && REG_ADDR == REG_ENABLE;
  assign wr_pending = REG_WR && REG_ADDR == REG_PENDING;
  assign wr_flags   = REG_WR && REG_ADDR == REG_FLAGS;
  assign wr_control = REG_WR && REG_ADDR == REG_CONTROL;

  // ---------------- register file ----------------
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      enable <= ENABLE_RST;
    end else if (wr_enable) begin
      enable <= REG_WDATA[NSRC-1:0];
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      trap_dir_out   <= 1'b0;
      trap_pin_debug <= 1'b0;
    end else if (wr_control) begin
      trap_dir_out   <= REG_WDATA[CTL_TRAP_OUT_BIT];
      trap_pin_debug <= REG_WDATA[CTL_TRAP_DEBUG_BIT];
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      REG_RDATA <= '0;
    end else if (REG_RD) begin
      case (REG_ADDR)
        REG_ENABLE:  REG_RDATA <= DW'(enable);
        REG_PENDING: REG_RDATA <= DW'(pending);
        REG_FLAGS: begin
          REG_RDATA                   <= '0;
          REG_RDATA[FLAG_SLEEP_BIT]   <= sleep_bit;
          REG_RDATA[FLAG_RAM_LOW_BIT] <= ram_low;
        end
        REG_CONTROL: REG_RDATA <= DW'({trap_pin_debug, trap_dir_out});
        REG_STATUS:  REG_RDATA <= DW'({CORE_SLEEP, trap_debug, trap_st, isr_active,
                                       SERVICE_ACK_OUT, SERVICE_CODE_OUT});
        default:     REG_RDATA <= '0;
      endcase
    end else begin
      REG_RDATA <= '0;
    end
  end

  // ---------------- pending flags ----------------
  // data-register accesses clear the peripheral flags; ext and timer bits are write-one
  assign clr_access = SRC_DATA_ACCESS & ~W1C_MASK;
  assign clr_write  = wr_pending ? (REG_WDATA[NSRC-1:0] & W1C_MASK) : '0;

  always_comb begin
    clr_return = '0;
    if (IRETURN && trap_st != VITU_TR_ACTIVE && isr_active && !isr_is_sw) begin
      clr_return[isr_src] = W1C_MASK[isr_src];
    end
  end

  // a new event in the clearing cycle survives: set wins
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pending <= PENDING_RST;
    end else begin
      pending <= (pending & ~(clr_access | clr_write | clr_return)) | SRC_EVENT;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sw_pending <= 1'b0;
    end else if (SW_CALL) begin
      sw_pending <= 1'b1;
    end else if (int_take && !pick.found) begin
      sw_pending <= 1'b0;
    end
  end

  // ---------------- vectored interrupt entry ----------------
  // masked bits never reach the selector, so they wait in pending until unmasked
  assign pick     = pick_highest(pending & enable);
  assign int_ok   = INSTR_DONE && INSTR_INTERRUPTIBLE && !isr_active;
  // a trap taking control this cycle has precedence over any vectored entry
  assign int_take = int_ok && (pick.found || sw_pending) && !trap_take
                    && trap_st != VITU_TR_ACTIVE;

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      isr_active <= 1'b0;
      isr_src    <= '0;
      isr_is_sw  <= 1'b0;
      isr_svc    <= '0;
    end else if (int_take) begin
      isr_active <= 1'b1;
      isr_src    <= pick.idx;
      isr_is_sw  <= !pick.found;
      isr_svc    <= pick.found ? {1'b1, SRC_CODE[pick.idx]} : {1'b1, SW_CODE};
    end else if (IRETURN && trap_st != VITU_TR_ACTIVE) begin
      isr_active <= 1'b0;
      isr_svc    <= {1'b0, IDLE_CODE};
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      TAKE_VALID  <= 1'b0;
      TAKE_VECTOR <= '0;
    end else begin
      TAKE_VALID <= trap_take || int_take;
      if (trap_take) begin
        TAKE_VECTOR <= trap_debug ? DTRAP_VECTOR : UTRAP_VECTOR;
      end else if (int_take) begin
        TAKE_VECTOR <= pick.found ? SRC_VECTOR[pick.idx] : SW_VECTOR;
      end
    end
  end

  // ---------------- service status pins ----------------
  // a debug trap keeps showing whatever service state was in force
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      SERVICE_ACK_OUT  <= 1'b0;
      SERVICE_CODE_OUT <= IDLE_CODE;
    end else if (trap_st == VITU_TR_ACTIVE && !trap_debug) begin
      SERVICE_ACK_OUT  <= 1'b1;
      SERVICE_CODE_OUT <= UTRAP_CODE;
    end else begin
      SERVICE_ACK_OUT  <= isr_svc.ack;
      SERVICE_CODE_OUT <= isr_svc.code;
    end
  end

  // ---------------- traps ----------------
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      trap_in_q <= 1'b0;
    end else begin
      trap_in_q <= TRAP_IN && !trap_dir_out;
    end
  end

  // pin edge only counts while the pin is an input
  assign trap_req_debug = DEBUG_BREAK || (trap_pin_debug && TRAP_IN && !trap_in_q);
  assign trap_req       = DEBUG_BREAK || (!trap_dir_out && TRAP_IN && !trap_in_q);
  // waits for the instruction boundary so wait-stated instructions complete first
  assign trap_take = INSTR_DONE && ((trap_st == VITU_TR_WAIT
                     && trap_cnt == 3'(TRAP_LAT_CYC - 1))
                     || trap_st == VITU_TR_ARMED);

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      trap_st    <= VITU_TR_IDLE;
      trap_cnt   <= '0;
      trap_debug <= 1'b0;
    end else begin
      case (trap_st)
        VITU_TR_IDLE: begin
          if (trap_req) begin
            trap_st    <= VITU_TR_WAIT;
            trap_cnt   <= 3'h1;
            trap_debug <= trap_req_debug;
          end
        end
        VITU_TR_WAIT: begin
          if (trap_take) begin
            trap_st <= VITU_TR_ACTIVE;
          end else if (trap_cnt == 3'(TRAP_LAT_CYC - 1)) begin
            trap_st <= VITU_TR_ARMED;
          end else begin
            trap_cnt <= trap_cnt + 3'h1;
          end
        end
        VITU_TR_ARMED: begin
          if (trap_take) begin
            trap_st <= VITU_TR_ACTIVE;
          end
        end
        VITU_TR_ACTIVE: begin
          // further trap requests fall through unheard here
          if (IRETURN) begin
            trap_st <= VITU_TR_IDLE;
          end
        end
        default: trap_st <= VITU_TR_IDLE;
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      TRAP_OUT <= 1'b0;
      TRAP_OE  <= 1'b0;
    end else begin
      TRAP_OE  <= trap_dir_out;
      TRAP_OUT <= trap_dir_out && DEBUG_BREAK;
    end
  end

  // ---------------- return pointer ----------------
  // it only updates while no vectored interrupt routine runs, so a trap inside a routine leaves it for the routine's return
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      SAVED_RETURN_POINTER <= '0;
    end else if (INSTR_DONE && !isr_active) begin
      SAVED_RETURN_POINTER <= INSTR_TWO_CYCLE ? NEXT_PC : NEXT_PC + 16'h0001;
    end
  end

  // ---------------- program map ----------------
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ram_low <= 1'b0;
    end else if (wr_flags) begin
      ram_low <= REG_WDATA[FLAG_RAM_LOW_BIT];
    end
  end

  // user choice is held untouched, so leaving the debug trap restores it
  assign ROM_LOW_PROGRAM_MAP = trap_st == VITU_TR_ACTIVE && trap_debug;
  assign PROGRAM_RAM_LOW     = ram_low && !ROM_LOW_PROGRAM_MAP;

  // ---------------- sleep ----------------
  // any interrupt event or trap counts as the waking interrupt
  assign wake = |SRC_EVENT || SW_CALL || trap_req;

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sleep_bit <= 1'b0;
    end else if (wake) begin
      sleep_bit <= 1'b0;
    end else if (wr_flags) begin
      sleep_bit <= REG_WDATA[FLAG_SLEEP_BIT];
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sleep_armed <= 1'b0;
      CORE_SLEEP  <= 1'b0;
    end else if (wake || !sleep_bit) begin
      sleep_armed <= 1'b0;
      CORE_SLEEP  <= 1'b0;
    end else begin
      if (INSTR_DONE) begin
        sleep_armed <= 1'b1;
      end
      if (sleep_armed && !XFER_BUSY) begin
        CORE_SLEEP <= 1'b1;
      end
    end
  end

  // ---------------- checks ----------------
  property p_mask_blocks;
    @(posedge REF_CLK) disable iff (!RST_N)
    int_take && pick.found |-> enable[pick.idx];
  endproperty
  a_mask_blocks: assert property (p_mask_blocks) else $error("masked source taken");

  property p_latch_masked;
    @(posedge REF_CLK) disable iff (!RST_N)
    SRC_EVENT[SRC_TIMER] |=> pending[SRC_TIMER];
  endproperty
  a_latch_masked: assert property (p_latch_masked) else $error("event not latched");

  property p_take_vector;
    @(posedge REF_CLK) disable iff (!RST_N)
    int_take && pick.found |=> TAKE_VALID && TAKE_VECTOR == SRC_VECTOR[$past(pick.idx)];
  endproperty
  a_take_vector: assert property (p_take_vector) else $error("wrong vector");

  property p_no_nest;
    @(posedge REF_CLK) disable iff (!RST_N)
    isr_active |-> !int_take;
  endproperty
  a_no_nest: assert property (p_no_nest) else $error("nested interrupt");

  property p_ack_follows;
    @(posedge REF_CLK) disable iff (!RST_N)
    int_take |=> ##1 SERVICE_ACK_OUT && SERVICE_CODE_OUT != IDLE_CODE;
  endproperty
  a_ack_follows: assert property (p_ack_follows) else $error("ack missing");

  property p_idle_code;
    @(posedge REF_CLK) disable iff (!RST_N)
    !SERVICE_ACK_OUT |-> SERVICE_CODE_OUT == IDLE_CODE;
  endproperty
  a_idle_code: assert property (p_idle_code) else $error("code not zero idle");

  property p_w1c;
    @(posedge REF_CLK) disable iff (!RST_N)
    wr_pending && REG_WDATA[SRC_EXT_A] && !SRC_EVENT[SRC_EXT_A] |=> !pending[SRC_EXT_A];
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear");

  property p_trap_latency;
    @(posedge REF_CLK) disable iff (!RST_N)
    trap_st == VITU_TR_IDLE && trap_req && INSTR_DONE ##1 INSTR_DONE[*3]
      |=> TAKE_VALID && (TAKE_VECTOR == UTRAP_VECTOR || TAKE_VECTOR == DTRAP_VECTOR);
  endproperty
  a_trap_latency: assert property (p_trap_latency) else $error("trap latency");

  property p_trap_ignored;
    @(posedge REF_CLK) disable iff (!RST_N)
    trap_st == VITU_TR_ACTIVE && !IRETURN |=> trap_st == VITU_TR_ACTIVE
      && trap_debug == $past(trap_debug);
  endproperty
  a_trap_ignored: assert property (p_trap_ignored) else $error("trap re-entered");

  property p_debug_map;
    @(posedge REF_CLK) disable iff (!RST_N)
    trap_take && trap_debug |=> ROM_LOW_PROGRAM_MAP && !PROGRAM_RAM_LOW;
  endproperty
  a_debug_map: assert property (p_debug_map) else $error("map not forced");

  property p_debug_status;
    @(posedge REF_CLK) disable iff (!RST_N)
    trap_st == VITU_TR_ACTIVE && trap_debug && $stable(isr_svc)
      |=> $stable(SERVICE_ACK_OUT) && $stable(SERVICE_CODE_OUT);
  endproperty
  a_debug_status: assert property (p_debug_status) else $error("debug trap moved pins");

  property p_wake;
    @(posedge REF_CLK) disable iff (!RST_N)
    CORE_SLEEP && wake |=> !CORE_SLEEP && !sleep_bit;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on interrupt");

endmodule

// ===== design/vitu_pkg.sv
// constants, tables and types shared by the vectored interrupt and trap unit
package vitu_pkg;
  localparam int DW   = 16;
  localparam int AW   = 3;
  localparam int NSRC = 10;

  // register indices on the local register port
  localparam logic [AW-1:0] REG_ENABLE  = 3'h0;
  localparam logic [AW-1:0] REG_PENDING = 3'h1;
  localparam logic [AW-1:0] REG_FLAGS   = 3'h2;
  localparam logic [AW-1:0] REG_CONTROL = 3'h3;
  localparam logic [AW-1:0] REG_STATUS  = 3'h4;

  // auxiliary flags register fields
  localparam int FLAG_SLEEP_BIT   = 15;
  localparam int FLAG_RAM_LOW_BIT = 14;
  // control register fields
  localparam int CTL_TRAP_OUT_BIT   = 0;
  localparam int CTL_TRAP_DEBUG_BIT = 1;

  // reset values
  localparam logic [NSRC-1:0] ENABLE_RST  = 10'h000;
  localparam logic [NSRC-1:0] PENDING_RST = 10'h000;

  // source order: ext a, scan, ext b, timer, serial b in/out, serial a in/out, host in/out
  localparam int SRC_EXT_A = 0;
  localparam int SRC_EXT_B = 2;
  localparam int SRC_TIMER = 3;
  // sources cleared by pending write-one or by the service return
  localparam logic [NSRC-1:0] W1C_MASK = 10'h00D;

  localparam logic [NSRC-1:0][DW-1:0] SRC_VECTOR = {
    16'h0038, 16'h0034, 16'h0030, 16'h002C, 16'h0018,
    16'h0014, 16'h0010, 16'h0004, 16'h0042, 16'h0001};
  localparam logic [NSRC-1:0][4:0] SRC_PRIO = {
    5'h11, 5'h10, 5'h0F, 5'h0E, 5'h09, 5'h08, 5'h07, 5'h04, 5'h03, 5'h02};
  localparam logic [NSRC-1:0][3:0] SRC_CODE = {
    4'h6, 4'h5, 4'h4, 4'h3, 4'hE, 4'hD, 4'hC, 4'h9, 4'h8, 4'h2};

  localparam logic [DW-1:0] SW_VECTOR    = 16'h0002;
  localparam logic [3:0]    SW_CODE      = 4'h1;
  localparam logic [DW-1:0] UTRAP_VECTOR = 16'h0046;
  localparam logic [DW-1:0] DTRAP_VECTOR = 16'h0003;
  localparam logic [3:0]    UTRAP_CODE   = 4'h7;
  localparam logic [3:0]    IDLE_CODE    = 4'h0;

  // trap latency in core cycles from pin to control
  localparam int TRAP_LAT_CYC = 4;

  typedef struct packed {
    logic       ack;
    logic [3:0] code;
  } vitu_svc_t;

  typedef struct packed {
    logic       found;
    logic [3:0] idx;
  } vitu_pick_t;

  typedef enum logic [1:0] {
    VITU_TR_IDLE   = 2'b00,
    VITU_TR_WAIT   = 2'b01,
    VITU_TR_ARMED  = 2'b11,
    VITU_TR_ACTIVE = 2'b10
  } vitu_trap_st_t;
endpackage
